// [logic/gpcfg_pkg.sv]
// Constants and types for the GPIO port pin control block
package gpcfg_pkg;
    localparam int GPCFG_PIN_W = 8;
    localparam int GPCFG_PIN_IDX_W = 3;
    localparam int GPCFG_CMD_W = 4;
    localparam int GPCFG_RES_W = 2;

    // Direction bit encoding
    localparam logic GPCFG_DIR_IN = 1'h0;
    localparam logic GPCFG_DIR_OUT = 1'h1;

    // Option command codes, sequential from zero
    localparam logic [3:0] GPCFG_CMD_CMOS = 4'h0;
    localparam logic [3:0] GPCFG_CMD_N_OPEN_DRAIN = 4'h1;
    localparam logic [3:0] GPCFG_CMD_P_OPEN_DRAIN = 4'h2;
    localparam logic [3:0] GPCFG_CMD_PULL_UP_OFF = 4'h3;
    localparam logic [3:0] GPCFG_CMD_PULL_UP_ON = 4'h4;
    localparam logic [3:0] GPCFG_CMD_ASSIGN_PERIPHERAL = 4'h5;
    localparam logic [3:0] GPCFG_CMD_ASSIGN_GENERAL_IO = 4'h6;
    localparam logic [3:0] GPCFG_CMD_DRIVE_CAP_OFF = 4'h7;
    localparam logic [3:0] GPCFG_CMD_DRIVE_CAP_ON = 4'h8;
    localparam logic [3:0] GPCFG_CMD_HS_DRIVE_OFF = 4'h9;
    localparam logic [3:0] GPCFG_CMD_HS_DRIVE_ON = 4'hA;

    // Option results; ok is zero so any nonzero result is an error
    localparam logic [1:0] GPCFG_RESULT_OK = 2'h0;
    localparam logic [1:0] GPCFG_RESULT_BAD_MODE = 2'h1;
    localparam logic [1:0] GPCFG_RESULT_BAD_CMD = 2'h2;

    // Output drive type per pin
    localparam logic [1:0] GPCFG_DRV_CMOS = 2'h0;
    localparam logic [1:0] GPCFG_DRV_NOD = 2'h1;
    localparam logic [1:0] GPCFG_DRV_POD = 2'h2;

    // Reset values
    localparam logic [7:0] GPCFG_RST_LEVEL = 8'h00;
    localparam logic [7:0] GPCFG_RST_DIR = 8'h00;
    localparam logic [7:0] GPCFG_RST_ZERO = 8'h00;
endpackage

// [logic/gpcfg_pin_opt.sv]
// Per-pin option state and option command decode
`timescale 1ns/1ps
`default_nettype none
module gpcfg_pin_opt
    import gpcfg_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic sel_i,
    input wire logic [3:0] cmd_i,
    input wire logic present_i,
    input wire logic od_n_ok_i,
    input wire logic od_p_ok_i,
    input wire logic pull_ok_i,
    input wire logic cap_ok_i,
    input wire logic hs_ok_i,
    output logic [1:0] drv_q,
    output logic pull_q,
    output logic periph_q,
    output logic cap_q,
    output logic hs_q,
    output logic [1:0] result_o
);
    logic [1:0] drv_d;
    logic pull_d;
    logic periph_d;
    logic cap_d;
    logic hs_d;
    logic ok;

    always_comb
    begin
        drv_d = drv_q;
        pull_d = pull_q;
        periph_d = periph_q;
        cap_d = cap_q;
        hs_d = hs_q;
        ok = 1'b0;
        result_o = GPCFG_RESULT_OK;
        // (R12) Sequential command codes
        // (R13) Result classification
        unique case (cmd_i)
            GPCFG_CMD_CMOS: ok = present_i;
            GPCFG_CMD_N_OPEN_DRAIN: ok = present_i & od_n_ok_i;
            GPCFG_CMD_P_OPEN_DRAIN: ok = present_i & od_p_ok_i;
            GPCFG_CMD_PULL_UP_OFF, GPCFG_CMD_PULL_UP_ON: ok = present_i & pull_ok_i;
            GPCFG_CMD_ASSIGN_PERIPHERAL, GPCFG_CMD_ASSIGN_GENERAL_IO: ok = present_i;
            // (R15) Fixed drive rejected
            GPCFG_CMD_DRIVE_CAP_OFF, GPCFG_CMD_DRIVE_CAP_ON: ok = present_i & cap_ok_i;
            GPCFG_CMD_HS_DRIVE_OFF, GPCFG_CMD_HS_DRIVE_ON: ok = present_i & hs_ok_i;
            default: ok = 1'b0;
        endcase
        if (cmd_i > GPCFG_CMD_HS_DRIVE_ON)
        begin
            result_o = GPCFG_RESULT_BAD_CMD;
        end
        else if (!ok)
        begin
            result_o = GPCFG_RESULT_BAD_MODE;
        end
        // (R11) Apply option command
        if (sel_i && ok)
        begin
            unique case (cmd_i)
                GPCFG_CMD_CMOS: drv_d = GPCFG_DRV_CMOS;
                GPCFG_CMD_N_OPEN_DRAIN: drv_d = GPCFG_DRV_NOD;
                GPCFG_CMD_P_OPEN_DRAIN: drv_d = GPCFG_DRV_POD;
                GPCFG_CMD_PULL_UP_OFF: pull_d = 1'b0;
                GPCFG_CMD_PULL_UP_ON: pull_d = 1'b1;
                // (R18) Peripheral or GPIO use
                GPCFG_CMD_ASSIGN_PERIPHERAL: periph_d = 1'b1;
                GPCFG_CMD_ASSIGN_GENERAL_IO: periph_d = 1'b0;
                GPCFG_CMD_DRIVE_CAP_OFF: cap_d = 1'b0;
                GPCFG_CMD_DRIVE_CAP_ON: cap_d = 1'b1;
                GPCFG_CMD_HS_DRIVE_OFF: hs_d = 1'b0;
                GPCFG_CMD_HS_DRIVE_ON: hs_d = 1'b1;
                default: drv_d = drv_q;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            // (R16) CMOS default
            drv_q <= GPCFG_DRV_CMOS;
            // (R17) Pull-up off default
            pull_q <= 1'b0;
            periph_q <= 1'b0;
            cap_q <= 1'b0;
            hs_q <= 1'b0;
        end
        else
        begin
            drv_q <= drv_d;
            pull_q <= pull_d;
            periph_q <= periph_d;
            cap_q <= cap_d;
            hs_q <= hs_d;
        end
    end
endmodule
`default_nettype wire

// [logic/gpcfg_port.sv]
// Eight-pin GPIO port: levels, directions, per-pin options
//
// Overview of operation
// (R1) Port write sets output level of pin n from value bit n.
// (R2) Software writes only existing pins; port write does no filtering.
// (R3) Port read returns all pin levels, bit n is pin n.
// (R4) Masked direction update touches only pins whose mask bit is one.
// (R5) Direction bit: zero is input, one is output.
// (R6) Single-pin write: one drives high, zero drives low.
// (R7) Single-pin writes and direction changes leave other pins alone.
// (R8) Single-pin read returns the addressed pin's present level.
// (R9) Each pin's direction can be set on its own.
// (R10) Direction updates never alter pull-up or open-drain settings.
// (R11) Pins take option commands: open drain, pull-up, drive capacity.
// (R12) Option commands are coded sequentially from zero in fixed order.
// (R13) Option result is ok, invalid mode or invalid command.
// (R14) Ok result is zero; nonzero means error.
// (R15) Drive change on fixed-drive pin gives invalid mode.
// (R16) Outputs default to push-pull CMOS drive.
// (R17) Pull-up is disabled until enabled by command.
// (R18) Each pin is assignable to peripheral or GPIO use.
// (R19) Validity mask has ones for existing pins only.
`timescale 1ns/1ps
`default_nettype none
module gpcfg_port
    import gpcfg_pkg::*;
#(
    parameter logic [7:0] PIN_PRESENT = 8'hFF,
    parameter logic [7:0] OD_N_OK = 8'hFF,
    parameter logic [7:0] OD_P_OK = 8'hFF,
    parameter logic [7:0] PULL_OK = 8'hFF,
    parameter logic [7:0] CAP_OK = 8'hFF,
    parameter logic [7:0] HS_OK = 8'h00
)
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic port_wr_i,
    input wire logic [7:0] port_wdata_i,
    input wire logic dir_wr_i,
    input wire logic dir_val_i,
    input wire logic [7:0] dir_mask_i,
    input wire logic pin_wr_i,
    input wire logic pin_dir_wr_i,
    input wire logic [2:0] pin_sel_i,
    input wire logic pin_val_i,
    input wire logic opt_wr_i,
    input wire logic [3:0] opt_cmd_i,
    input wire logic [7:0] pad_in_i,
    output logic [7:0] port_rdata_o,
    output logic pin_rdata_o,
    output logic opt_done_o,
    output logic [1:0] opt_result_o,
    output logic [7:0] valid_mask_o,
    output logic [7:0] pad_out_o,
    output logic [7:0] pad_oe_o,
    output logic [7:0] pull_up_o,
    output logic [7:0] periph_sel_o,
    output logic [7:0] drive_capacity_select_o,
    output logic [7:0] high_speed_drive_select_o
);
    // ------------------------------------------------------------
    // Level and direction state
    // ------------------------------------------------------------
    logic [7:0] level_q;
    logic [7:0] level_d;
    logic [7:0] dir_q;
    logic [7:0] dir_d;
    logic [7:0] port_rdata_d;
    logic pin_rdata_d;
    logic [7:0] pin_onehot;
    logic [7:0] pad_out_d;
    logic [7:0] pad_oe_d;
    logic [1:0] drv_q [GPCFG_PIN_W];
    logic [7:0] pull_q;
    logic [7:0] periph_q;
    logic [7:0] cap_q;
    logic [7:0] hs_q;
    logic [1:0] res_w [GPCFG_PIN_W];

    assign pin_onehot = 8'h01 << pin_sel_i;

    always_comb
    begin
        level_d = level_q;
        dir_d = dir_q;
        // (R1) Port-wide write, unfiltered
        if (port_wr_i)
        begin
            level_d = port_wdata_i;
        end
        // (R6) Single-pin level
        // (R7) Other pins kept
        if (pin_wr_i)
        begin
            level_d[pin_sel_i] = pin_val_i;
        end
        // (R4) Masked direction update
        // (R5) Direction encoding
        if (dir_wr_i)
        begin
            dir_d = (dir_q & ~dir_mask_i) | (dir_mask_i & {GPCFG_PIN_W{dir_val_i}});
        end
        // (R9) Per-pin direction
        if (pin_dir_wr_i)
        begin
            dir_d[pin_sel_i] = pin_val_i;
        end
        // (R3) Port-wide read
        port_rdata_d = pad_in_i;
        // (R8) Single-pin read
        pin_rdata_d = pad_in_i[pin_sel_i];
    end

    // ------------------------------------------------------------
    // Pad drive from direction, level and drive type
    // ------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < GPCFG_PIN_W; i++)
        begin
            pad_out_d[i] = level_d[i];
            // Open drain drives only its active level; the other is released
            if (drv_q[i] == GPCFG_DRV_NOD)
            begin
                pad_oe_d[i] = dir_d[i] & ~level_d[i];
            end
            else if (drv_q[i] == GPCFG_DRV_POD)
            begin
                pad_oe_d[i] = dir_d[i] & level_d[i];
            end
            else
            begin
                pad_oe_d[i] = dir_d[i];
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            level_q <= GPCFG_RST_LEVEL;
            dir_q <= GPCFG_RST_DIR;
            port_rdata_o <= GPCFG_RST_ZERO;
            pin_rdata_o <= 1'b0;
            pad_out_o <= GPCFG_RST_LEVEL;
            pad_oe_o <= GPCFG_RST_ZERO;
            valid_mask_o <= GPCFG_RST_ZERO;
        end
        else
        begin
            level_q <= level_d;
            dir_q <= dir_d;
            port_rdata_o <= port_rdata_d;
            pin_rdata_o <= pin_rdata_d;
            pad_out_o <= pad_out_d;
            pad_oe_o <= pad_oe_d;
            // (R19) Existing pins mask
            valid_mask_o <= PIN_PRESENT;
        end
    end

    // ------------------------------------------------------------
    // Per-pin options
    // ------------------------------------------------------------
    // (R10) Options apart from direction
    for (genvar g = 0; g < GPCFG_PIN_W; g++)
    begin : g_pin
        gpcfg_pin_opt u_opt (
            .core_clk_i(core_clk_i),
            .srst_i(srst_i),
            .sel_i(opt_wr_i & pin_onehot[g]),
            .cmd_i(opt_cmd_i),
            .present_i(PIN_PRESENT[g]),
            .od_n_ok_i(OD_N_OK[g]),
            .od_p_ok_i(OD_P_OK[g]),
            .pull_ok_i(PULL_OK[g]),
            .cap_ok_i(CAP_OK[g]),
            .hs_ok_i(HS_OK[g]),
            .drv_q(drv_q[g]),
            .pull_q(pull_q[g]),
            .periph_q(periph_q[g]),
            .cap_q(cap_q[g]),
            .hs_q(hs_q[g]),
            .result_o(res_w[g])
        );
    end

    always_ff @(posedge core_clk_i)
    begin
        if (srst_i)
        begin
            opt_done_o <= 1'b0;
            opt_result_o <= GPCFG_RESULT_OK;
            pull_up_o <= GPCFG_RST_ZERO;
            periph_sel_o <= GPCFG_RST_ZERO;
            drive_capacity_select_o <= GPCFG_RST_ZERO;
            high_speed_drive_select_o <= GPCFG_RST_ZERO;
        end
        else
        begin
            opt_done_o <= opt_wr_i;
            // (R14) Zero means ok
            if (opt_wr_i)
            begin
                opt_result_o <= res_w[pin_sel_i];
            end
            // Pull-up only acts on inputs; it follows dir_q, so it drops one cycle after pad_oe_o rises
            pull_up_o <= pull_q & ~dir_q;
            periph_sel_o <= periph_q;
            drive_capacity_select_o <= cap_q;
            high_speed_drive_select_o <= hs_q;
        end
    end
endmodule
`default_nettype wire

// [verification/gpcfg_pad_model.sv]
// Pad and external circuit model for the GPIO port
`timescale 1ns/1ps
`default_nettype none
module gpcfg_pad_model
(
    input wire logic core_clk_i,
    input wire logic [7:0] pad_out_i,
    input wire logic [7:0] pad_oe_i,
    input wire logic [7:0] pull_up_i,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pad_o
);
    // Undriven pads without pull-up toggle so a floating line never reads as a fixed level
    logic [7:0] float_q = 8'h55;
    always @(posedge core_clk_i)
        float_q <= ~float_q;
    always_comb
        for (int i = 0; i < 8; i++)
            pad_o[i] = pad_oe_i[i] ? pad_out_i[i] : ext_en_i[i] ? ext_val_i[i] : pull_up_i[i] | float_q[i];
endmodule
`default_nettype wire

// [verification/gpcfg_port_asserts.sv]
// Concurrent checks on the GPIO port pins
`timescale 1ns/1ps
`default_nettype none
module gpcfg_port_asserts
    import gpcfg_pkg::*;
#(
    parameter logic [7:0] PIN_PRESENT = 8'hFF,
    parameter logic [7:0] CAP_OK = 8'hFF
)
(
    input wire logic core_clk_i,
    input wire logic srst_i,
    input wire logic port_wr_i,
    input wire logic [7:0] port_wdata_i,
    input wire logic dir_wr_i,
    input wire logic dir_val_i,
    input wire logic [7:0] dir_mask_i,
    input wire logic pin_wr_i,
    input wire logic pin_dir_wr_i,
    input wire logic [2:0] pin_sel_i,
    input wire logic pin_val_i,
    input wire logic opt_wr_i,
    input wire logic [3:0] opt_cmd_i,
    input wire logic [7:0] pad_in_i,
    input wire logic [7:0] port_rdata_o,
    input wire logic opt_done_o,
    input wire logic [1:0] opt_result_o,
    input wire logic [7:0] valid_mask_o,
    input wire logic [7:0] pad_out_o,
    input wire logic [7:0] pad_oe_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    property p_port_wr;
        port_wr_i && !pin_wr_i |=> pad_out_o == $past(port_wdata_i);
    endproperty
    a_port_wr: assert property (p_port_wr) else $error("port write level wrong");
    property p_dir_mask;
        dir_wr_i && !dir_val_i && !pin_dir_wr_i |=> (pad_oe_o & $past(dir_mask_i)) == 8'h00;
    endproperty
    a_dir_mask: assert property (p_dir_mask) else $error("masked pin still driven");
    property p_pin_wr;
        pin_wr_i && !port_wr_i |=> pad_out_o[$past(pin_sel_i)] == $past(pin_val_i)
            && ((pad_out_o ^ $past(pad_out_o)) & ~(8'h01 << $past(pin_sel_i))) == 8'h00;
    endproperty
    a_pin_wr: assert property (p_pin_wr) else $error("pin write wrong");
    property p_port_rd;
        !srst_i |=> port_rdata_o == $past(pad_in_i);
    endproperty
    a_port_rd: assert property (p_port_rd) else $error("port read wrong");
    property p_done;
        !srst_i |=> opt_done_o == $past(opt_wr_i);
    endproperty
    a_done: assert property (p_done) else $error("option done wrong");
    property p_bad_cmd;
        opt_wr_i && opt_cmd_i > GPCFG_CMD_HS_DRIVE_ON |=> opt_result_o == GPCFG_RESULT_BAD_CMD;
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("unknown command accepted");
    property p_cap_fixed;
        opt_wr_i && opt_cmd_i == GPCFG_CMD_DRIVE_CAP_ON && !CAP_OK[pin_sel_i] |=> opt_result_o == GPCFG_RESULT_BAD_MODE;
    endproperty
    a_cap_fixed: assert property (p_cap_fixed) else $error("fixed drive change accepted");
    property p_valid;
        !srst_i |=> valid_mask_o == PIN_PRESENT;
    endproperty
    a_valid: assert property (p_valid) else $error("validity mask wrong");
    c_bad_cmd: cover property (opt_wr_i && opt_cmd_i > GPCFG_CMD_HS_DRIVE_ON);
    c_mask: cover property (dir_wr_i && dir_mask_i != 8'h00);
    c_bad_mode: cover property (opt_done_o && opt_result_o == GPCFG_RESULT_BAD_MODE);
endmodule
bind gpcfg_port gpcfg_port_asserts #(.PIN_PRESENT(PIN_PRESENT), .CAP_OK(CAP_OK)) u_chk (.*);
`default_nettype wire

// [verification/gpcfg_port_tb.sv]
// Self-checking testbench for the GPIO port
`timescale 1ns/1ps
`default_nettype none
module gpcfg_port_tb
    import gpcfg_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic port_wr_i = 1'b0, dir_wr_i = 1'b0, dir_val_i = 1'b0, pin_wr_i = 1'b0;
    logic pin_dir_wr_i = 1'b0, pin_val_i = 1'b0, opt_wr_i = 1'b0, pin_rdata_o, opt_done_o;
    logic [7:0] port_wdata_i = 8'h00, dir_mask_i = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
    logic [2:0] pin_sel_i = 3'h0;
    logic [3:0] opt_cmd_i = 4'h0;
    logic [1:0] opt_result_o;
    logic [7:0] pad_in_i, port_rdata_o, valid_mask_o, pad_out_o, pad_oe_o, pull_up_o, periph_sel_o;
    logic [7:0] drive_capacity_select_o, high_speed_drive_select_o;
    int errors = 0, check_count = 0;
    localparam logic [4:0] PW = 5'h10, DW = 5'h08, NW = 5'h04, ND = 5'h02, OW = 5'h01;
    always #5 core_clk_i = ~core_clk_i;
    // Pin 2 absent, pin 7 has fixed drive
    gpcfg_port #(.PIN_PRESENT(8'hFB), .CAP_OK(8'h7F)) dut (.*);
    gpcfg_pad_model pads (.core_clk_i(core_clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
        .pull_up_i(pull_up_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pad_o(pad_in_i));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick();
        {port_wr_i, dir_wr_i, pin_wr_i, pin_dir_wr_i, opt_wr_i} = 5'h00;
        @(negedge core_clk_i);
    endtask
    // Strobes stay up until the next op or tick, so nothing is set twice in one step
    task automatic op(input logic [4:0] s, input logic [2:0] sel, input logic v, input logic [7:0] d);
        {port_wr_i, dir_wr_i, pin_wr_i, pin_dir_wr_i, opt_wr_i} = s;
        pin_sel_i = sel;
        pin_val_i = v;
        dir_val_i = v;
        port_wdata_i = d;
        dir_mask_i = d;
        opt_cmd_i = d[3:0];
        @(negedge core_clk_i);
    endtask
    task automatic opt(input logic [2:0] sel, input logic [3:0] c, input logic [1:0] r);
        op(OW, sel, 1'b0, {4'h0, c});
        check("opt_done", opt_done_o, 8'h01);
        check("opt_result", opt_result_o, r);
        tick();
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(negedge core_clk_i);
        srst_i = 1'b0;
        check("pull_up", pull_up_o, 8'h00);
        check("periph", periph_sel_o, 8'h00);
        tick();
        check("valid", valid_mask_o, 8'hFB);
        op(DW, 3'h0, GPCFG_DIR_OUT, 8'hFF);
        check("pad_oe", pad_oe_o, 8'hFF);
        op(PW, 3'h0, 1'b0, 8'hAA);
        check("pad_out", pad_out_o, 8'hAA);
        tick();
        check("port_rd", port_rdata_o, 8'hAA);
        op(DW, 3'h0, GPCFG_DIR_IN, 8'h23);
        check("pad_oe", pad_oe_o, 8'hDC);
        op(ND, 3'h1, GPCFG_DIR_OUT, 8'h00);
        check("pad_oe", pad_oe_o, 8'hDE);
        op(NW, 3'h0, 1'b1, 8'h00);
        check("pad_out", pad_out_o, 8'hAB);
        op(NW, 3'h7, 1'b0, 8'h00);
        check("pad_out", pad_out_o, 8'h2B);
        ext_en = 8'h01;
        ext_val = 8'h01;
        pin_sel_i = 3'h0;
        tick();
        check("pin_rd", pin_rdata_o, 8'h01);
        ext_val = 8'h00;
        tick();
        check("pin_rd", pin_rdata_o, 8'h00);
        // Every code: 0..8 accepted, high-speed unsupported, rest unknown
        for (int c = 0; c < 16; c++)
            opt(3'h6, c[3:0], c < 9 ? GPCFG_RESULT_OK : c < 11 ? GPCFG_RESULT_BAD_MODE : GPCFG_RESULT_BAD_CMD);
        check("cap_sel", drive_capacity_select_o, 8'h40);
        check("hs_sel", high_speed_drive_select_o, 8'h00);
        opt(3'h7, GPCFG_CMD_DRIVE_CAP_ON, GPCFG_RESULT_BAD_MODE);
        check("cap_sel", drive_capacity_select_o, 8'h40);
        opt(3'h2, GPCFG_CMD_PULL_UP_ON, GPCFG_RESULT_BAD_MODE);
        opt(3'h4, GPCFG_CMD_ASSIGN_PERIPHERAL, GPCFG_RESULT_OK);
        check("periph", periph_sel_o, 8'h10);
        opt(3'h5, GPCFG_CMD_PULL_UP_ON, GPCFG_RESULT_OK);
        check("pull_up", pull_up_o, 8'h20);
        tick();
        check("pin_rd", pin_rdata_o, 8'h01);
        op(DW, 3'h0, GPCFG_DIR_OUT, 8'h20);
        op(DW, 3'h0, GPCFG_DIR_IN, 8'h20);
        tick();
        check("pull_up", pull_up_o, 8'h20);
        // Pin 6 was left P-channel open drain at low level, so it stays released
        opt(3'h3, GPCFG_CMD_N_OPEN_DRAIN, GPCFG_RESULT_OK);
        check("pad_oe", pad_oe_o, 8'h96);
        op(NW, 3'h3, 1'b0, 8'h00);
        check("pad_oe", pad_oe_o, 8'h9E);
        summarize();
    end
    initial
    begin
        #20us;
        errors++;
        summarize();
    end
endmodule
`default_nettype wire
